/* File: verilog/wtc_timer.sv */
//
// Contract
// (RQ1) Codes six/seven count external pin edges
// (RQ2) Force bit makes immediate match, non-PWM only
// (RQ3) Forced match raises no flag, no clear
// (RQ4) Force bits are strobes, read zero
// (RQ5) Low byte at offset, high next
// (RQ6) Shared high-byte latch for 16-bit access
// (RQ7) Counter readable and writable by CPU
// (RQ8) Counter write blocks next-tick compare matches
// (RQ9) Software avoids changing running counter
// (RQ10) Capture event copies counter into capture
// (RQ11) Capture register may serve as top
// (RQ12) Compare registers continuously matched against counter
// (RQ13) Nonzero action field overrides port pin
// (RQ14) Software sets pin direction to output
// (RQ15) Software sets port latch for B
// (RQ16) Non-PWM actions: none, toggle, clear, set
// (RQ17) Action meaning depends on waveform mode
// (RQ18) Channel control bit layout 7:6,5:4,1:0
// (RQ19) Normal and clear-on-match are non-PWM modes
// (RQ20) Clock code zero stops the counter
// (RQ21) External pin synchronised and edge detected
`timescale 1ns/1ps
`include "wtc_defines.svh"

module wtc_timer
    import wtc_pkg::*;
#(
    parameter int PRESCALE_W = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Pins and comparator
    input wire logic i_external_count_pin,
    input wire logic i_capture_pin,
    input wire logic i_acmp_out,
    // Compare outputs
    output logic o_compare_out_a,
    output logic o_compare_out_a_ovr,
    output logic o_compare_out_b,
    output logic o_compare_out_b_ovr,
    // Events
    output logic o_match_a,
    output logic o_match_b,
    output logic o_capture_evt
);

    wtc_word_t cnt_r;
    wtc_word_t cap_r;
    wtc_word_t cmpa_r;
    wtc_word_t cmpb_r;
    wtc_byte_t temp_r;
    logic [2:0] clock_source_select_r;
    logic [1:0] wgm_hi_r;
    logic [1:0] wgm_lo_r;
    logic cap_edge_r;
    logic cap_acmp_r;
    wtc_action_t act_a_r;
    wtc_action_t act_b_r;
    logic [PRESCALE_W-1:0] pre_r;
    logic ext_s1_r, ext_s2_r, ext_s3_r;
    logic icp_s1_r, icp_s2_r, icp_s3_r;
    logic acmp_d_r;
    logic blk_r;
    logic out_a_r, out_b_r;
    logic [3:0] waveform_mode_select;
    logic tick;
    logic nonpwm;
    logic top_is_cap;
    wtc_word_t top;
    logic hit_a, hit_b;
    logic force_a, force_b;
    logic cap_src, cap_src_d, cap_evt;
    logic wr_cnt;

    assign waveform_mode_select = {wgm_hi_r, wgm_lo_r};
    assign wr_cnt = i_wr && (i_addr == `WTC_OFS_CNT_LO);

    // Free-running prescaler; never stopped, the select only gates the tick, not reset on change
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Two-stage synchronisers plus one delay stage for edge detection on both pins; the comparator gets only the delay stage
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            icp_s1_r <= 1'b0;
            icp_s2_r <= 1'b0;
            icp_s3_r <= 1'b0;
            acmp_d_r <= 1'b0;
        end else begin
            ext_s1_r <= i_external_count_pin; // [RQ21]
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            icp_s1_r <= i_capture_pin;
            icp_s2_r <= icp_s1_r;
            icp_s3_r <= icp_s2_r;
            acmp_d_r <= i_acmp_out;
        end
    end

    always_comb begin
        case (clock_source_select_r)
            `WTC_CS_STOP: tick = 1'b0; // [RQ20]
            `WTC_CS_DIV1: tick = 1'b1;
            `WTC_CS_DIV8: tick = &pre_r[2:0];
            `WTC_CS_DIV64: tick = &pre_r[5:0];
            `WTC_CS_DIV256: tick = &pre_r[7:0];
            `WTC_CS_DIV1024: tick = &pre_r[9:0];
            `WTC_CS_EXT_FALL: tick = !ext_s2_r && ext_s3_r; // [RQ1] [RQ21]
            `WTC_CS_EXT_RISE: tick = ext_s2_r && !ext_s3_r; // [RQ1] [RQ21]
            default: tick = 1'b0;
        endcase
    end

    // Top select; capture register as top also disconnects capture
    always_comb begin
        top_is_cap = 1'b0;
        case (waveform_mode_select)
            4'h1, 4'h5: top = `WTC_TOP_8BIT;
            4'h2, 4'h6: top = `WTC_TOP_9BIT;
            4'h3, 4'h7: top = `WTC_TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top = cmpa_r;
            4'h8, 4'hA, 4'hC, 4'hE: begin
                top = cap_r; // [RQ11]
                top_is_cap = 1'b1;
            end
            default: top = `WTC_TOP_MAX; // [RQ19]
        endcase
    end

    assign nonpwm = (waveform_mode_select == `WTC_MODE_NORMAL) ||
                    (waveform_mode_select == `WTC_MODE_CTC_CMPA) ||
                    (waveform_mode_select == `WTC_MODE_CTC_CAP); // [RQ19]

    assign hit_a = tick && !blk_r && (cnt_r == cmpa_r); // [RQ12] [RQ8]
    assign hit_b = tick && !blk_r && (cnt_r == cmpb_r); // [RQ12] [RQ8]

    assign force_a = i_wr && (i_addr == `WTC_OFS_FORCE) && i_wdata[`WTC_BIT_FORCE_A] && nonpwm; // [RQ2]
    assign force_b = i_wr && (i_addr == `WTC_OFS_FORCE) && i_wdata[`WTC_BIT_FORCE_B] && nonpwm; // [RQ2]

    assign cap_src = cap_acmp_r ? i_acmp_out : icp_s2_r;
    assign cap_src_d = cap_acmp_r ? acmp_d_r : icp_s3_r;
    assign cap_evt = !top_is_cap && (cap_edge_r ? (cap_src && !cap_src_d) : (!cap_src && cap_src_d));

    // Control registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clock_source_select_r <= `WTC_CS_STOP;
            wgm_hi_r <= 2'h0;
            cap_edge_r <= 1'b0;
            cap_acmp_r <= 1'b0;
            act_a_r <= WTC_ACT_OFF;
            act_b_r <= WTC_ACT_OFF;
            wgm_lo_r <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == `WTC_OFS_CLK_CTRL) begin
                cap_edge_r <= i_wdata[`WTC_BIT_CAP_EDGE];
                wgm_hi_r <= i_wdata[4:3];
                clock_source_select_r <= i_wdata[2:0];
            end
            if (i_addr == `WTC_OFS_CAP_SRC) begin
                cap_acmp_r <= i_wdata[`WTC_BIT_CAP_ACMP];
            end
            if (i_addr == `WTC_OFS_CHAN_CTRL) begin
                act_a_r <= wtc_action_t'(i_wdata[7:6]); // [RQ18]
                act_b_r <= wtc_action_t'(i_wdata[5:4]); // [RQ18]
                wgm_lo_r <= i_wdata[1:0]; // [RQ18]
            end
        end
    end

    // Shared high-byte latch: high writes park here, low reads fill it
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            temp_r <= `WTC_RST_BYTE;
        end else if (i_wr) begin
            case (i_addr)
                `WTC_OFS_CNT_HI, `WTC_OFS_CAP_HI, `WTC_OFS_CMPA_HI, `WTC_OFS_CMPB_HI: temp_r <= i_wdata; // [RQ6]
                default: temp_r <= temp_r;
            endcase
        end else if (i_rd) begin
            case (i_addr)
                `WTC_OFS_CNT_LO: temp_r <= cnt_r[15:8]; // [RQ6]
                `WTC_OFS_CAP_LO: temp_r <= cap_r[15:8];
                `WTC_OFS_CMPA_LO: temp_r <= cmpa_r[15:8];
                `WTC_OFS_CMPB_LO: temp_r <= cmpb_r[15:8];
                default: temp_r <= temp_r;
            endcase
        end
    end

    // Counter; a forced match never reaches this clear path
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r <= `WTC_RST_WORD;
        end else if (wr_cnt) begin
            cnt_r <= {temp_r, i_wdata}; // [RQ6] [RQ7]
        end else if (tick) begin
            if (cnt_r == top) begin
                cnt_r <= `WTC_RST_WORD; // [RQ19] [RQ3]
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Match blocking after a counter write; a new write wins over the clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blk_r <= 1'b0;
        end else if (wr_cnt) begin
            blk_r <= 1'b1; // [RQ8]
        end else if (tick) begin
            blk_r <= 1'b0;
        end
    end

    // Capture register; a capture event wins over a CPU write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cap_r <= `WTC_RST_WORD;
        end else if (cap_evt) begin
            cap_r <= cnt_r; // [RQ10]
        end else if (i_wr && (i_addr == `WTC_OFS_CAP_LO)) begin
            cap_r <= {temp_r, i_wdata}; // [RQ6]
        end
    end

    // Compare registers update immediately in every mode
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmpa_r <= `WTC_RST_WORD;
            cmpb_r <= `WTC_RST_WORD;
        end else if (i_wr) begin
            if (i_addr == `WTC_OFS_CMPA_LO) begin
                cmpa_r <= {temp_r, i_wdata}; // [RQ6]
            end
            if (i_addr == `WTC_OFS_CMPB_LO) begin
                cmpb_r <= {temp_r, i_wdata}; // [RQ6]
            end
        end
    end

    // Waveform outputs; PWM waveforms are not produced here, outputs hold
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
        end else if (nonpwm) begin // [RQ17]
            if (hit_a || force_a) begin
                case (act_a_r) // [RQ16] [RQ2]
                    WTC_ACT_TOGGLE: out_a_r <= !out_a_r;
                    WTC_ACT_CLEAR: out_a_r <= 1'b0;
                    WTC_ACT_SET: out_a_r <= 1'b1;
                    default: out_a_r <= out_a_r;
                endcase
            end
            if (hit_b || force_b) begin
                case (act_b_r) // [RQ16] [RQ2]
                    WTC_ACT_TOGGLE: out_b_r <= !out_b_r;
                    WTC_ACT_CLEAR: out_b_r <= 1'b0;
                    WTC_ACT_SET: out_b_r <= 1'b1;
                    default: out_b_r <= out_b_r;
                endcase
            end
        end
    end

    assign o_compare_out_a = out_a_r;
    assign o_compare_out_b = out_b_r;
    assign o_compare_out_a_ovr = (act_a_r != WTC_ACT_OFF); // [RQ13]
    assign o_compare_out_b_ovr = (act_b_r != WTC_ACT_OFF); // [RQ13]

    // Event pulses come only from real matches and capture events, never from a force strobe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_match_a <= 1'b0;
            o_match_b <= 1'b0;
            o_capture_evt <= 1'b0;
        end else begin
            o_match_a <= hit_a; // [RQ3] [RQ12]
            o_match_b <= hit_b; // [RQ3] [RQ12]
            o_capture_evt <= cap_evt;
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= `WTC_RST_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `WTC_OFS_CAP_SRC: o_rdata <= {7'h00, cap_acmp_r};
                `WTC_OFS_CLK_CTRL: o_rdata <= {1'b0, cap_edge_r, 1'b0, wgm_hi_r, clock_source_select_r};
                `WTC_OFS_FORCE: o_rdata <= 8'h00; // [RQ4]
                `WTC_OFS_CNT_LO: o_rdata <= cnt_r[7:0]; // [RQ5] [RQ7]
                `WTC_OFS_CAP_LO: o_rdata <= cap_r[7:0]; // [RQ5]
                `WTC_OFS_CMPA_LO: o_rdata <= cmpa_r[7:0]; // [RQ5]
                `WTC_OFS_CMPB_LO: o_rdata <= cmpb_r[7:0]; // [RQ5]
                `WTC_OFS_CNT_HI, `WTC_OFS_CAP_HI, `WTC_OFS_CMPA_HI, `WTC_OFS_CMPB_HI: o_rdata <= temp_r; // [RQ6]
                `WTC_OFS_CHAN_CTRL: o_rdata <= {act_a_r, act_b_r, 2'h0, wgm_lo_r}; // [RQ18]
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_force_reads_zero;
        i_rd && (i_addr == `WTC_OFS_FORCE) |=> (o_rdata == 8'h00);
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero) // [RQ4]
        else $error("force register read not zero");

    property p_force_no_event;
        (force_a || force_b) && !hit_a && !hit_b |=> !o_match_a && !o_match_b;
    endproperty
    a_force_no_event: assert property (p_force_no_event) // [RQ3]
        else $error("force strobe raised a match event");

    property p_force_action;
        force_a && !hit_a && (act_a_r == WTC_ACT_SET) |=> o_compare_out_a;
    endproperty
    a_force_action: assert property (p_force_action) // [RQ2]
        else $error("forced set did not drive output high");

    property p_write_blocks;
        wr_cnt ##1 (!wr_cnt && tick) |-> !hit_a && !hit_b ##1 !blk_r;
    endproperty
    a_write_blocks: assert property (p_write_blocks) // [RQ8]
        else $error("match not blocked after counter write");

    property p_cnt_write;
        wr_cnt |=> (cnt_r == {$past(temp_r), $past(i_wdata)});
    endproperty
    a_cnt_write: assert property (p_cnt_write) // [RQ6]
        else $error("counter write not atomic");

    property p_hi_read;
        i_rd && (i_addr == `WTC_OFS_CNT_LO) ##1 i_rd && (i_addr == `WTC_OFS_CNT_HI)
            |=> (o_rdata == $past(cnt_r[15:8], 2));
    endproperty
    a_hi_read: assert property (p_hi_read) // [RQ5]
        else $error("high byte not latched on low read");

    property p_capture;
        cap_evt |=> (cap_r == $past(cnt_r)) && o_capture_evt;
    endproperty
    a_capture: assert property (p_capture) // [RQ10]
        else $error("capture did not copy counter");

    property p_toggle;
        nonpwm && hit_a && (act_a_r == WTC_ACT_TOGGLE) |=> (o_compare_out_a != $past(o_compare_out_a));
    endproperty
    a_toggle: assert property (p_toggle) // [RQ16]
        else $error("toggle action failed");

    property p_override;
        i_wr && (i_addr == `WTC_OFS_CHAN_CTRL) |=> (o_compare_out_b_ovr == (|$past(i_wdata[5:4])));
    endproperty
    a_override: assert property (p_override) // [RQ13]
        else $error("pin override does not follow action field");

    property p_stopped;
        (clock_source_select_r == `WTC_CS_STOP) && !wr_cnt |=> $stable(cnt_r);
    endproperty
    a_stopped: assert property (p_stopped) // [RQ20]
        else $error("counter moved while stopped");

    property p_ext_rise;
        (clock_source_select_r == `WTC_CS_EXT_RISE) && !wr_cnt && (cnt_r != top) && ext_s2_r && !ext_s3_r
            |=> (cnt_r == $past(cnt_r) + 16'h0001);
    endproperty
    a_ext_rise: assert property (p_ext_rise) // [RQ1]
        else $error("rising pin edge did not count");

    property p_ctc_clear;
        (waveform_mode_select == `WTC_MODE_CTC_CMPA) && tick && !wr_cnt && (cnt_r == cmpa_r) |=> (cnt_r == 16'h0000);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) // [RQ19]
        else $error("clear-on-match did not clear");

    c_match_a: cover property (hit_a ##1 o_match_a);
    c_force_b: cover property (force_b);
    c_capture: cover property (cap_evt);
    c_ext_fall: cover property ((clock_source_select_r == `WTC_CS_EXT_FALL) && tick);

endmodule : wtc_timer

/* File: include/wtc_defines.svh */
`ifndef WTC_DEFINES_SVH
`define WTC_DEFINES_SVH

// Register byte offsets
`define WTC_OFS_CAP_SRC 8'h80
`define WTC_OFS_CLK_CTRL 8'h81
`define WTC_OFS_FORCE 8'h82
`define WTC_OFS_CNT_LO 8'h84
`define WTC_OFS_CNT_HI 8'h85
`define WTC_OFS_CAP_LO 8'h86
`define WTC_OFS_CAP_HI 8'h87
`define WTC_OFS_CMPA_LO 8'h88
`define WTC_OFS_CMPA_HI 8'h89
`define WTC_OFS_CMPB_LO 8'h8A
`define WTC_OFS_CMPB_HI 8'h8B
`define WTC_OFS_CHAN_CTRL 8'h90

// Field positions
`define WTC_BIT_FORCE_A 7
`define WTC_BIT_FORCE_B 6
`define WTC_BIT_CAP_EDGE 6
`define WTC_BIT_CAP_ACMP 0

// Reset values
`define WTC_RST_BYTE 8'h00
`define WTC_RST_WORD 16'h0000

// Clock source codes
`define WTC_CS_STOP 3'h0
`define WTC_CS_DIV1 3'h1
`define WTC_CS_DIV8 3'h2
`define WTC_CS_DIV64 3'h3
`define WTC_CS_DIV256 3'h4
`define WTC_CS_DIV1024 3'h5
`define WTC_CS_EXT_FALL 3'h6
`define WTC_CS_EXT_RISE 3'h7

// Waveform modes of interest and fixed tops
`define WTC_MODE_NORMAL 4'h0
`define WTC_MODE_CTC_CMPA 4'h4
`define WTC_MODE_CTC_CAP 4'hC
`define WTC_TOP_MAX 16'hFFFF
`define WTC_TOP_8BIT 16'h00FF
`define WTC_TOP_9BIT 16'h01FF
`define WTC_TOP_10BIT 16'h03FF

`endif

/* File: include/wtc_pkg.sv */
package wtc_pkg;
    typedef logic [15:0] wtc_word_t;
    typedef logic [7:0] wtc_byte_t;
    typedef enum logic [1:0] {WTC_ACT_OFF, WTC_ACT_TOGGLE, WTC_ACT_CLEAR, WTC_ACT_SET} wtc_action_t;
endpackage : wtc_pkg

/* File: testbench/wtc_pin_model.sv */
`timescale 1ns/1ps

module wtc_pin_model (
    // Clock
    input wire logic i_clk,
    // Pins toward the timer
    output logic o_ext_count,
    output logic o_capture,
    output logic o_acmp
);
    initial begin
        o_ext_count = 1'b0;
        o_capture = 1'b0;
        o_acmp = 1'b0;
    end

    // Count pin pulses; width sets a prompt or a slow partner
    task automatic ext_pulses(input int n, input int width);
        for (int i = 0; i < n; i++) begin
            repeat (width) @(posedge i_clk);
            o_ext_count <= 1'b1;
            repeat (width) @(posedge i_clk);
            o_ext_count <= 1'b0;
        end
        // Tail covers the synchroniser delay of the last edge
        repeat (4) @(posedge i_clk);
    endtask : ext_pulses

    // One rising then falling edge on the capture pin or comparator
    task automatic edge_pulse(input bit use_acmp, input int width);
        @(posedge i_clk);
        if (use_acmp) begin
            o_acmp <= 1'b1;
        end else begin
            o_capture <= 1'b1;
        end
        repeat (width) @(posedge i_clk);
        o_acmp <= 1'b0;
        o_capture <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : edge_pulse
endmodule : wtc_pin_model

/* File: testbench/wide_timer_compare_capture_regs_tb.sv */
`timescale 1ns/1ps

module wide_timer_compare_capture_regs_tb;
    import wtc_pkg::*;
    logic i_clk, i_nrst, i_wr, i_rd;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic ext_pin, cap_pin, acmp;
    logic o_compare_out_a, o_compare_out_a_ovr, o_compare_out_b, o_compare_out_b_ovr;
    logic o_match_a, o_match_b, o_capture_evt;
    int bad_count, checked, n_ma, n_mb, n_cap;
    // Port side of the shared pins, set up by software to let the waveform out
    logic dir_a = 1'b1;
    logic dir_b = 1'b1;
    logic port_output_latch_bit = 1'b1;
    wire pin_a = (o_compare_out_a_ovr && dir_a) ? o_compare_out_a : 1'b0;
    wire pin_b = (o_compare_out_b_ovr && dir_b && port_output_latch_bit) ? o_compare_out_b : 1'b0;
    localparam logic [7:0] OFS [13] = '{8'h80, 8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87,
                                        8'h88, 8'h89, 8'h8a, 8'h8b, 8'h90, 8'h83};

    wtc_timer #(.PRESCALE_W(10)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_external_count_pin(ext_pin), .i_capture_pin(cap_pin), .i_acmp_out(acmp),
        .o_compare_out_a(o_compare_out_a), .o_compare_out_a_ovr(o_compare_out_a_ovr),
        .o_compare_out_b(o_compare_out_b), .o_compare_out_b_ovr(o_compare_out_b_ovr),
        .o_match_a(o_match_a), .o_match_b(o_match_b), .o_capture_evt(o_capture_evt));

    wtc_pin_model pins (.i_clk(i_clk), .o_ext_count(ext_pin), .o_capture(cap_pin), .o_acmp(acmp));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Event pulses are one cycle long, so high cycles equal events
    always @(posedge i_clk) begin
        if (o_match_a === 1'b1) n_ma <= n_ma + 1;
        if (o_match_b === 1'b1) n_mb <= n_mb + 1;
        if (o_capture_evt === 1'b1) n_cap <= n_cap + 1;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask : rd

    // High byte parks in the shared latch, low byte commits the pair
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16

    // Back-to-back pair: the low read latches the high byte for the next strobe
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_addr <= a + 8'h01;
        @(negedge i_clk);
        v[7:0] = o_rdata;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        v[15:8] = o_rdata;
    endtask : rd16

    task automatic wait_change(ref int ctr, output int cycles);
        int base;
        base = ctr;
        cycles = 0;
        while (ctr == base) begin
            @(posedge i_clk);
            cycles++;
            if (cycles > 200) begin
                $display("[ERR] event_wait expected event seen none");
                bad_count++;
                complete_run();
            end
        end
    endtask : wait_change

    task automatic t_regs();
        logic [7:0] d;
        logic [15:0] v;
        chk("idle_outputs", {o_compare_out_a, o_compare_out_a_ovr, o_compare_out_b,
            o_compare_out_b_ovr, o_match_a, o_match_b, o_capture_evt}, 16'h0000);
        wr(8'h83, 8'hff);
        foreach (OFS[i]) begin
            rd(OFS[i], d);
            chk("reset_or_unmapped", d, 16'h0000);
        end
        wr(8'h90, 8'hff);
        rd(8'h90, d);
        chk("chan_ctrl_layout", d, 16'h00f3);
        chk("ovr_both", {o_compare_out_a_ovr, o_compare_out_b_ovr}, 16'h0003);
        wr(8'h90, 8'h10);
        @(negedge i_clk);
        chk("ovr_b_only", {o_compare_out_a_ovr, o_compare_out_b_ovr}, 16'h0001);
        wr(8'h90, 8'h00);
        wr16(8'h86, 16'hbeef);
        wr16(8'h88, 16'h1234);
        wr16(8'h8a, 16'h5a5a);
        rd16(8'h86, v);
        chk("capture_rw", v, 16'hbeef);
        rd16(8'h88, v);
        chk("cmp_a_rw", v, 16'h1234);
        rd16(8'h8a, v);
        chk("cmp_b_rw", v, 16'h5a5a);
        wr(8'h89, 8'h12);
        wr(8'h8a, 8'h34);
        rd16(8'h8a, v);
        chk("shared_latch", v, 16'h1234);
        wr16(8'h84, 16'h0100);
        repeat (10) @(posedge i_clk);
        rd16(8'h84, v);
        chk("counter_rw_stopped", v, 16'h0100);
        $display("test regs done");
    endtask : t_regs

    task automatic t_force();
        logic [1:0] acts [4] = '{2'b11, 2'b01, 2'b01, 2'b10};
        logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic [7:0] d;
        logic [15:0] v;
        int ma, mb;
        ma = n_ma;
        mb = n_mb;
        for (int i = 0; i < 4; i++) begin
            wr(8'h90, {acts[i], acts[i], 4'h0});
            wr(8'h82, 8'hc0);
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            chk("forced_out", {o_compare_out_a, o_compare_out_b}, {14'h0, exps[i], exps[i]});
        end
        rd(8'h82, d);
        chk("force_reads_zero", d, 16'h0000);
        wr(8'h90, 8'hf1);
        wr(8'h82, 8'hc0);
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("force_in_pwm", {o_compare_out_a, o_compare_out_b}, 16'h0000);
        wr(8'h90, 8'h00);
        wr(8'h81, 8'h08);
        wr16(8'h88, 16'h0005);
        wr16(8'h84, 16'h0005);
        wr(8'h82, 8'h80);
        repeat (3) @(posedge i_clk);
        rd16(8'h84, v);
        chk("force_no_clear", v, 16'h0005);
        chk("force_no_flags", 16'(n_ma - ma + n_mb - mb), 16'h0000);
        wr(8'h81, 8'h00);
        $display("test force done");
    endtask : t_force

    task automatic t_match();
        int c, ma;
        wr(8'h81, 8'h00); // Stop before touching the counter
        wr(8'h90, 8'h70);
        wr16(8'h88, 16'h0010);
        wr16(8'h8a, 16'h0012);
        wr16(8'h84, 16'h0008);
        wr(8'h81, 8'h01);
        wait_change(n_ma, c);
        @(negedge i_clk);
        chk("toggle_on_match", o_compare_out_a, 16'h0001);
        chk("pin_a_level", pin_a, 16'h0001);
        wait_change(n_mb, c);
        chk("match_spacing", 16'(c), 16'h0002);
        @(negedge i_clk);
        chk("set_on_match", o_compare_out_b, 16'h0001);
        chk("pin_b_level", pin_b, 16'h0001);
        ma = n_ma;
        wr16(8'h84, 16'h0010);
        repeat (4) @(posedge i_clk);
        chk("blocked_after_write", 16'(n_ma - ma), 16'h0000);
        wr(8'h81, 8'h00);
        wr(8'h90, 8'h00);
        $display("test match done");
    endtask : t_match

    task automatic t_ext();
        logic [15:0] v;
        wr16(8'h86, 16'h0005);
        wr16(8'h84, 16'h0000);
        wr(8'h81, 8'h1f);
        pins.ext_pulses(7, 4);
        wr(8'h81, 8'h18);
        rd16(8'h84, v);
        chk("ext_rise_capture_top", v, 16'h0001);
        wr(8'h81, 8'h00);
        wr16(8'h84, 16'h0000);
        wr(8'h81, 8'h06);
        pins.ext_pulses(3, 2);
        wr(8'h81, 8'h00);
        rd16(8'h84, v);
        chk("ext_fall_count", v, 16'h0003);
        $display("test ext done");
    endtask : t_ext

    task automatic t_capture();
        logic [15:0] v;
        int n;
        wr(8'h80, 8'h00);
        wr16(8'h84, 16'h0abc);
        wr(8'h81, 8'h40);
        n = n_cap;
        pins.edge_pulse(1'b0, 4);
        chk("capture_events", 16'(n_cap - n), 16'h0001);
        rd16(8'h86, v);
        chk("capture_pin_value", v, 16'h0abc);
        wr(8'h80, 8'h01);
        wr16(8'h84, 16'h0123);
        n = n_cap;
        pins.edge_pulse(1'b1, 2);
        chk("acmp_events", 16'(n_cap - n), 16'h0001);
        rd16(8'h86, v);
        chk("acmp_value", v, 16'h0123);
        $display("test capture done");
    endtask : t_capture

    // Windows are whole multiples of each divide, so prescaler phase does not matter
    task automatic t_prescale();
        logic [2:0] sel [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
        int span [4] = '{80, 128, 512, 2048};
        logic [15:0] cnt_exp [4] = '{16'h000a, 16'h0002, 16'h0002, 16'h0002};
        logic [15:0] v;
        for (int i = 0; i < 4; i++) begin
            wr16(8'h84, 16'h0000);
            wr(8'h81, {5'h00, sel[i]});
            repeat (span[i] - 2) @(posedge i_clk);
            wr(8'h81, 8'h00);
            rd16(8'h84, v);
            chk("prescaled_count", v, cnt_exp[i]);
        end
        wr16(8'h88, 16'h0005);
        wr16(8'h84, 16'h0000);
        wr(8'h81, 8'h09);
        repeat (11) @(posedge i_clk);
        wr(8'h81, 8'h08);
        rd16(8'h84, v);
        chk("ctc_wrap", v, 16'h0001);
        wr(8'h81, 8'h00);
        $display("test prescale done");
    endtask : t_prescale

    initial begin
        i_nrst = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_force();
        t_match();
        t_ext();
        t_capture();
        t_prescale();
        complete_run();
    end
endmodule : wide_timer_compare_capture_regs_tb
